// File: include/gmon_regs.svh
// Register offsets, reset values, scaling figures and timing figures of the gas monitor.
`ifndef GMON_REGS_SVH
`define GMON_REGS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define GMON_OFS_CTRL 8'h00
`define GMON_OFS_ALARM 8'h04
`define GMON_OFS_WARN_PCT 8'h08
`define GMON_OFS_BASE 8'h0C
`define GMON_OFS_SPAN 8'h10
`define GMON_OFS_STATUS 8'h14
// ****************************************
// Reset values
// ****************************************
`define GMON_RST_CTRL 8'h26
`define GMON_RST_ALARM 8'h64
`define GMON_RST_WARN_PCT 8'h32
`define GMON_RST_BASE 8'h10
`define GMON_RST_SPAN 8'h80
// ****************************************
// Scaling and range
// ****************************************
`define GMON_SPAN_SHIFT 7
`define GMON_STEPS_VOLT 8'hFA
`define GMON_STEPS_LOOP 8'hD0
`define GMON_PCT_FULL 16'h0064
`define GMON_FILT_SHIFT 2
// ****************************************
// Timing figures
// ****************************************
`define GMON_CLK_KHZ 100000
`define GMON_WARMUP_MS 2000
`define GMON_BLINK_MS 500
`define GMON_ERR_PERIOD_MS 10000
`define GMON_ERR_PULSE_MS 100
`endif

// File: include/gmon_pkg.sv
// Types shared by the gas monitor design and its bench.
package gmon_pkg;
  // ****************************************
  // Device states, Gray coded along the usual path
  // ****************************************
  typedef enum logic [2:0] {
    GMON_WARMUP = 3'h0,
    GMON_NORMAL = 3'h1,
    GMON_WARNING = 3'h3,
    GMON_ALARM = 3'h2,
    GMON_ERROR = 3'h6
  } gmon_state_t;
  // ****************************************
  // Output configuration, bit order as held in the control register
  // ****************************************
  typedef struct packed {
    logic loop_mode;
    logic relay_nc;
    logic relay_latch;
    logic [1:0] relay_trig;
    logic ttl_idle_high;
    logic ttl_latch;
    logic [1:0] ttl_trig;
  } gmon_cfg_t;
  // ****************************************
  // Fault inputs
  // ****************************************
  typedef struct packed {
    logic sensor;
    logic temp;
    logic cksum;
  } gmon_fault_t;
  // ****************************************
  // Bi-color indicator
  // ****************************************
  typedef struct packed {
    logic red;
    logic green;
  } gmon_led_t;
endpackage

// File: rtl/gmon_top.sv
// Gas monitor controller: filtering, calibration, state sequencing and output drive.
// Function
// - Enter warm-up at every power-on, stay about two seconds, then sense.
// - During warm-up sensing is inactive and reading is zero everywhere.
// - During warm-up the indicator blinks green and off.
// - Readings and state indications become valid only after warm-up ends.
// - Exactly five states, each with its own indicator and output combination.
// - Sample the 8-bit converter continuously and filter out burst noise.
// - Subtract stored baseline from filtered sample, then scale by stored span.
// - Scaled value is a linear reading offered live to all outputs.
// - Reading steps 100 ppm up to 25000 ppm, 120 ppm in loop variants.
// - Binary output idle level selectable by build default or by the link.
// - Binary output latching or auto-reset, triggered by warning, alarm or both.
// - Relay normally open or closed, latching or auto-reset, selectable trigger.
// - Auto-reset output returns inactive once its cause has cleared.
// - Latching output holds active until reset button or power cycle.
// - Reset button press clears a latched relay or binary output.
// - An external host sets up, calibrates, monitors and changes thresholds.
// - Normal state holds the indicator steady green.
// - Warning at stored percentage of alarm threshold; blink red and green.
// - Alarm when reading reaches alarm threshold; blink red and off.
// - Any fault gives error: full-scale reading, indicator off, red pulse each 10 s.
`timescale 1ns/1ps
`include "gmon_regs.svh"

module gmon_top
  import gmon_pkg::*;
#(
  parameter int unsigned WARMUP_CYC = `GMON_WARMUP_MS * `GMON_CLK_KHZ,
  parameter int unsigned BLINK_CYC = `GMON_BLINK_MS * `GMON_CLK_KHZ,
  parameter int unsigned ERR_PERIOD_CYC = `GMON_ERR_PERIOD_MS * `GMON_CLK_KHZ,
  parameter int unsigned ERR_PULSE_CYC = `GMON_ERR_PULSE_MS * `GMON_CLK_KHZ,
  parameter logic [7:0] CTRL_DEFAULT = `GMON_RST_CTRL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter, fault sources and reset button
  input wire logic [7:0] adc_data,
  input wire logic adc_valid,
  input wire gmon_fault_t fault,
  input wire logic reset_btn,
  // Indicator and signalling outputs
  output gmon_led_t led,
  output logic ttl_out,
  output logic relay_closed,
  output logic [7:0] reading,
  output logic reading_valid,
  output gmon_state_t state
);

  // ****************************************
  // Register file and bus slave
  // ****************************************
  gmon_cfg_t cfg;
  gmon_cfg_t next_cfg;
  logic [7:0] alarm_th;
  logic [7:0] next_alarm_th;
  logic [7:0] warn_pct;
  logic [7:0] next_warn_pct;
  logic [7:0] baseline;
  logic [7:0] next_baseline;
  logic [7:0] span;
  logic [7:0] next_span;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_en;
  logic ttl_latched;
  logic relay_latched;

  // The answer is prepared in the setup cycle, so every access phase ends after one cycle.
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    next_cfg = cfg;
    next_alarm_th = alarm_th;
    next_warn_pct = warn_pct;
    next_baseline = baseline;
    next_span = span;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = psel & ~penable;
    if (psel & ~penable) begin
      unique case (paddr)
        `GMON_OFS_CTRL: next_prdata = {23'h00_0000, cfg};
        `GMON_OFS_ALARM: next_prdata = {24'h00_0000, alarm_th};
        `GMON_OFS_WARN_PCT: next_prdata = {24'h00_0000, warn_pct};
        `GMON_OFS_BASE: next_prdata = {24'h00_0000, baseline};
        `GMON_OFS_SPAN: next_prdata = {24'h00_0000, span};
        `GMON_OFS_STATUS: next_prdata = {16'h0000, reading, 1'b0, relay_latched, ttl_latched,
                                         reading_valid, 1'b0, state};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        `GMON_OFS_CTRL: next_cfg = gmon_cfg_t'(pwdata[8:0]);
        `GMON_OFS_ALARM: next_alarm_th = pwdata[7:0];
        `GMON_OFS_WARN_PCT: next_warn_pct = pwdata[7:0];
        `GMON_OFS_BASE: next_baseline = pwdata[7:0];
        `GMON_OFS_SPAN: next_span = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg <= gmon_cfg_t'({1'b0, CTRL_DEFAULT});
      alarm_th <= `GMON_RST_ALARM;
      warn_pct <= `GMON_RST_WARN_PCT;
      baseline <= `GMON_RST_BASE;
      span <= `GMON_RST_SPAN;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      alarm_th <= next_alarm_th;
      warn_pct <= next_warn_pct;
      baseline <= next_baseline;
      span <= next_span;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Sample filter and calibration
  // ****************************************
  logic [9:0] filt_acc;
  logic [9:0] next_filt_acc;
  logic [7:0] filt;
  logic [7:0] diff;
  logic [15:0] product;
  logic [15:0] scaled;
  logic [7:0] max_steps;
  logic [7:0] level;

  assign filt = filt_acc[9:2];
  assign max_steps = cfg.loop_mode ? `GMON_STEPS_LOOP : `GMON_STEPS_VOLT;

  always_comb begin
    next_filt_acc = filt_acc;
    if (adc_valid) begin
      next_filt_acc = filt_acc - (filt_acc >> `GMON_FILT_SHIFT) + {2'b00, adc_data};
    end
    diff = (filt > baseline) ? 8'(filt - baseline) : 8'h00;
    product = 16'(diff) * 16'(span);
    scaled = product >> `GMON_SPAN_SHIFT;
    level = (scaled > 16'(max_steps)) ? max_steps : scaled[7:0];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      filt_acc <= 10'h000;
    end else begin
      filt_acc <= next_filt_acc;
    end
  end

  // ****************************************
  // State sequencing
  // ****************************************
  logic [31:0] warm_cnt;
  logic [31:0] next_warm_cnt;
  gmon_state_t next_state;
  logic [15:0] warn_level;
  logic any_fault;
  logic [7:0] next_reading;
  logic next_reading_valid;

  // Percent of the threshold; a division by a constant keeps the stored figure in plain percent.
  assign warn_level = 16'((16'(alarm_th) * 16'(warn_pct)) / `GMON_PCT_FULL);
  assign any_fault = fault.sensor | fault.temp | fault.cksum;

  always_comb begin
    next_warm_cnt = warm_cnt;
    next_state = state;
    unique case (state)
      GMON_WARMUP: begin
        if (warm_cnt >= WARMUP_CYC - 1) begin
          next_state = GMON_NORMAL;
        end else begin
          next_warm_cnt = warm_cnt + 32'h0000_0001;
        end
      end
      default: begin
        if (any_fault) begin
          next_state = GMON_ERROR;
        end else if (level >= alarm_th) begin
          next_state = GMON_ALARM;
        end else if (16'(level) >= warn_level) begin
          next_state = GMON_WARNING;
        end else begin
          next_state = GMON_NORMAL;
        end
      end
    endcase
    next_reading = 8'h00;
    next_reading_valid = 1'b0;
    if (state == GMON_ERROR) begin
      next_reading = max_steps;
      next_reading_valid = 1'b1;
    end else if (state != GMON_WARMUP) begin
      next_reading = level;
      next_reading_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      warm_cnt <= 32'h0000_0000;
      state <= GMON_WARMUP;
      reading <= 8'h00;
      reading_valid <= 1'b0;
    end else begin
      warm_cnt <= next_warm_cnt;
      state <= next_state;
      reading <= next_reading;
      reading_valid <= next_reading_valid;
    end
  end

  // ****************************************
  // Indicator timing
  // ****************************************
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink_ph;
  logic next_blink_ph;
  logic [31:0] err_cnt;
  logic [31:0] next_err_cnt;
  gmon_led_t next_led;

  always_comb begin
    next_blink_cnt = blink_cnt + 32'h0000_0001;
    next_blink_ph = blink_ph;
    if (blink_cnt >= BLINK_CYC - 1) begin
      next_blink_cnt = 32'h0000_0000;
      next_blink_ph = ~blink_ph;
    end
    // The error pulse restarts on entry so the first flash starts one pulse length short of a full period away.
    next_err_cnt = 32'h0000_0000;
    if (state == GMON_ERROR) begin
      next_err_cnt = (err_cnt >= ERR_PERIOD_CYC - 1) ? 32'h0000_0000 : err_cnt + 32'h0000_0001;
    end
    next_led = '{red: 1'b0, green: 1'b0};
    unique case (state)
      GMON_WARMUP: next_led.green = blink_ph;
      GMON_NORMAL: next_led.green = 1'b1;
      GMON_WARNING: begin
        next_led.red = blink_ph;
        next_led.green = ~blink_ph;
      end
      GMON_ALARM: next_led.red = blink_ph;
      GMON_ERROR: next_led.red = (err_cnt >= ERR_PERIOD_CYC - ERR_PULSE_CYC);
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt <= 32'h0000_0000;
      blink_ph <= 1'b1;
      err_cnt <= 32'h0000_0000;
      led <= '{red: 1'b0, green: 1'b0};
    end else begin
      blink_cnt <= next_blink_cnt;
      blink_ph <= next_blink_ph;
      err_cnt <= next_err_cnt;
      led <= next_led;
    end
  end

  // ****************************************
  // Binary output and relay
  // ****************************************
  logic ttl_cond;
  logic relay_cond;
  logic next_ttl_latched;
  logic next_relay_latched;
  logic ttl_active;
  logic relay_active;
  logic next_ttl_out;
  logic next_relay_closed;

  always_comb begin
    ttl_cond = (cfg.ttl_trig[0] & (state == GMON_WARNING)) | (cfg.ttl_trig[1] & (state == GMON_ALARM));
    relay_cond = (cfg.relay_trig[0] & (state == GMON_WARNING)) | (cfg.relay_trig[1] & (state == GMON_ALARM));
    // hold until button; a new activation wins over a press
    next_ttl_latched = ttl_cond | (ttl_latched & ~reset_btn);
    next_relay_latched = relay_cond | (relay_latched & ~reset_btn);
    ttl_active = cfg.ttl_latch ? ttl_latched : ttl_cond;
    relay_active = cfg.relay_latch ? relay_latched : relay_cond;
    next_ttl_out = ttl_active ^ cfg.ttl_idle_high;
    next_relay_closed = relay_active ^ cfg.relay_nc;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ttl_latched <= 1'b0;
      relay_latched <= 1'b0;
      ttl_out <= 1'b0;
      relay_closed <= 1'b0;
    end else begin
      ttl_latched <= next_ttl_latched;
      relay_latched <= next_relay_latched;
      ttl_out <= next_ttl_out;
      relay_closed <= next_relay_closed;
    end
  end

endmodule

// File: sim/gmon_top_asserts.sv
// Concurrent checks on the gas monitor ports.
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module gmon_chk
  import gmon_pkg::*;
#(
  parameter int unsigned WARMUP_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Sensing and outputs
  input wire gmon_fault_t fault,
  input wire gmon_led_t led,
  input wire logic [7:0] reading,
  input wire logic reading_valid,
  input wire gmon_state_t state
);
  logic [31:0] wcnt;
  logic [31:0] next_wcnt;
  // Edges since the last release; a short run never wraps it.
  always_comb begin
    next_wcnt = rstn ? wcnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    wcnt <= next_wcnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_warm_len: assert property ($past(state) == GMON_WARMUP && state == GMON_NORMAL |-> wcnt == WARMUP_CYC)
    else $error("warm-up length wrong");
  chk_warm_zero: assert property (state == GMON_WARMUP |=> reading == 8'h00 && !reading_valid)
    else $error("reading not zero in warm-up");
  chk_warm_led: assert property (state == GMON_WARMUP |=> !led.red)
    else $error("red lit in warm-up");
  chk_normal_led: assert property (state == GMON_NORMAL |=> led.green && !led.red)
    else $error("normal indicator not green");
  chk_warn_led: assert property (state == GMON_WARNING |=> led.red ^ led.green)
    else $error("warning indicator wrong");
  chk_alarm_led: assert property (state == GMON_ALARM |=> !led.green)
    else $error("green lit in alarm");
  chk_err_out: assert property (state == GMON_ERROR |=>
    !led.green && reading_valid && reading inside {8'hFA, 8'hD0})
    else $error("error outputs wrong");
  chk_err_enter: assert property (state != GMON_WARMUP && fault != 3'h0 |-> ##[1:3] state == GMON_ERROR)
    else $error("fault did not give error");
  chk_state_set: assert property (state inside {GMON_WARMUP, GMON_NORMAL, GMON_WARNING,
    GMON_ALARM, GMON_ERROR})
    else $error("illegal state code");
  // A stuck green would pass the red check above, so the off phase is watched as well.
  chk_warm_blink: assert property ($rose(led.green) && state == GMON_WARMUP |->
    ##[1:8] (!led.green || state != GMON_WARMUP))
    else $error("warm-up indicator not blinking");
  chk_bus_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer late or long");
endmodule
bind gmon_top gmon_chk #(.WARMUP_CYC(WARMUP_CYC)) u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pready(pready), .fault(fault), .led(led), .reading(reading), .reading_valid(reading_valid), .state(state));

// File: sim/gmon_host.sv
// Host model: register access over the bus that stands in for the configuration link.
`timescale 1ns/1ps
module gmon_host (
  // Clock
  input wire logic clk,
  // Bus
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready
);
  // Expected read results and compare masks, oldest first.
  logic [32:0] eq[$];
  logic [32:0] mq[$];
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                      input logic [32:0] m);
    @(posedge clk);
    if (!wr) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The request stands until the edge that samples the answer; only the bench watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: sim/gmon_top_bench.sv
// Self-checking bench for the gas monitor controller.
`timescale 1ns/1ps
`include "gmon_regs.svh"
module gmon_top_bench
  import gmon_pkg::*;
;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, adc_valid, reset_btn, ttl_out, relay_closed;
  logic reading_valid, noisy;
  logic [7:0] paddr, adc_data, reading, smp;
  logic [31:0] pwdata, prdata;
  logic [15:0] lfsr;
  gmon_fault_t fault;
  gmon_led_t led;
  gmon_state_t state;
  gmon_cfg_t cfg;
  int mismatches, comparisons, n;
  always #5 clk = ~clk;
  // Short counts keep the run brief; the checker follows the same warm-up figure.
  gmon_top #(.WARMUP_CYC(20), .BLINK_CYC(4), .ERR_PERIOD_CYC(40), .ERR_PULSE_CYC(4)) u_dut (.clk(clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_data(adc_data), .adc_valid(adc_valid),
    .fault(fault), .reset_btn(reset_btn), .led(led), .ttl_out(ttl_out), .relay_closed(relay_closed),
    .reading(reading), .reading_valid(reading_valid), .state(state));
  gmon_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    u_host.xfer(1'b0, a, 32'h0, e, 33'h1_FFFF_FFFF);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 33'h0, 33'h0);
  endtask
  task automatic st(input gmon_state_t s, input logic v, input logic [7:0] r, input logic mr);
    u_host.xfer(1'b0, `GMON_OFS_STATUS, 32'h0, {17'h0, r, 3'h0, v, 1'b0, s}, {17'h10000, mr ? 8'hFF : 8'h00, 8'h17});
  endtask
  // Filter settling: about a hundred samples bring the average to the new level exactly.
  task automatic settle(input logic [7:0] s);
    smp <= s;
    repeat (200) @(posedge clk);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask
  always @(posedge clk) begin
    lfsr <= lfsr_next(lfsr);
    adc_valid <= ~adc_valid;
    adc_data <= noisy ? smp + {6'h0, lfsr[1:0]} : smp;
  end
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      check("prdata", u_host.eq.pop_front(), {pslverr, prdata} & u_host.mq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    summarize();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    adc_valid = 1'b0;
    adc_data = 8'h00;
    reset_btn = 1'b0;
    fault = 3'h0;
    smp = 8'h14;
    noisy = 1'b1;
    lfsr = 16'h7D72;
    do_reset();
    st(GMON_WARMUP, 1'b0, 8'h00, 1'b1);
    rd(`GMON_OFS_ALARM, {25'h0, `GMON_RST_ALARM});
    rd(`GMON_OFS_WARN_PCT, {25'h0, `GMON_RST_WARN_PCT});
    rd(`GMON_OFS_SPAN, {25'h0, `GMON_RST_SPAN});
    rd(8'h18, 33'h1_0000_0000);
    n = 0;
    while (state !== GMON_NORMAL && n < 100) begin
      @(posedge clk);
      n++;
    end
    st(GMON_NORMAL, 1'b1, 8'h00, 1'b0);
    noisy <= 1'b0;
    cfg = '{loop_mode: 1'b0, relay_nc: 1'b0, relay_latch: 1'b1, relay_trig: 2'b10, ttl_idle_high: 1'b1,
            ttl_latch: 1'b0, ttl_trig: 2'b01};
    wr(`GMON_OFS_CTRL, {23'h0, cfg});
    settle(8'h14);
    check("ttl_out", 33'h1, 33'(ttl_out));
    settle(8'h4C);
    st(GMON_WARNING, 1'b1, 8'h3C, 1'b1);
    check("ttl_out", 33'h0, 33'(ttl_out));
    settle(8'h88);
    st(GMON_ALARM, 1'b1, 8'h78, 1'b1);
    check("ttl_out", 33'h1, 33'(ttl_out));
    check("relay_closed", 33'h1, 33'(relay_closed));
    settle(8'h14);
    st(GMON_NORMAL, 1'b1, 8'h04, 1'b1);
    check("relay_closed", 33'h1, 33'(relay_closed));
    reset_btn <= 1'b1;
    repeat (3) @(posedge clk);
    reset_btn <= 1'b0;
    repeat (3) @(posedge clk);
    check("relay_closed", 33'h0, 33'(relay_closed));
    wr(`GMON_OFS_SPAN, 32'h40);
    settle(8'h4C);
    st(GMON_NORMAL, 1'b1, 8'h1E, 1'b1);
    wr(`GMON_OFS_BASE, 32'h0);
    wr(`GMON_OFS_SPAN, 32'hFF);
    settle(8'hFF);
    st(GMON_ALARM, 1'b1, 8'hFA, 1'b1);
    fault <= 3'h4;
    n = 0;
    while (state !== GMON_ERROR && n < 10) begin
      @(posedge clk);
      n++;
    end
    // The alarm blink also lights red, so the pulse is only looked for once the error state holds.
    @(posedge clk);
    check("led", 33'h0, 33'(led));
    n = 0;
    while (led.red !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check("led_red", 33'h1, 33'(led.red));
    // With a period of 40 and a pulse of 4, the flash comes 36 edges after the first dark one.
    check("red_delay", 33'd36, 33'(n));
    st(GMON_ERROR, 1'b1, 8'hFA, 1'b1);
    fault <= 3'h0;
    settle(8'h14);
    st(GMON_NORMAL, 1'b1, 8'h27, 1'b1);
    do_reset();
    st(GMON_WARMUP, 1'b0, 8'h00, 1'b1);
    summarize();
  end
endmodule
